// ===== logic/perm_bank_pkg.sv
// Constants for the domain access-permission bank
package perm_bank_pkg;

  // ****************************************
  // Bus widths and responses
  // ****************************************
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_DOM10_11   = 12'h0C4;
  localparam logic [11:0] OFS_DOM12_13   = 12'h0C8;
  localparam logic [11:0] OFS_DOM14_15   = 12'h0CC;
  localparam logic [11:0] OFS_OVERRIDE   = 12'h0D0;
  localparam logic [11:0] OFS_ERR_ENABLE = 12'h100;
  localparam logic [11:0] OFS_ERR_CLEAR  = 12'h104;
  localparam logic [11:0] OFS_ERR_STATUS = 12'h108;

  // ****************************************
  // Reset values and writable-bit masks
  // ****************************************
  localparam logic [31:0] RST_DOMAIN     = 32'h0000_0000;
  localparam logic [31:0] RST_OVERRIDE   = 32'h0000_0000;
  localparam logic [31:0] RST_ERR        = 32'h0000_0000;
  localparam logic [31:0] MASK_DOMAIN    = 32'h3FFF_3FFF;
  localparam logic [31:0] MASK_OVERRIDE  = 32'h8000_3FFF;
  localparam logic [31:0] MASK_ERR       = 32'h0000_007F;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          MST_COUNT      = 7;
  localparam int          DOM_FIRST      = 10;
  localparam int          DOM_COUNT      = 6;
  localparam int          DOM_BITS       = 2 * MST_COUNT;
  localparam int          HI_DOMAIN_LSB  = 16;
  localparam int          OVR_ENABLE_BIT = 31;
  localparam int          READ_SLOT      = 0;
  localparam int          WRITE_SLOT     = 1;
  localparam logic [3:0]  DOM_FIRST_ID   = 4'hA;
  localparam logic [3:0]  DOM_LAST_ID    = 4'hF;

endpackage

// ===== logic/perm_check.sv
// One master's permission lookup against the domain bank
`timescale 1ns/1ps
module perm_check (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Permission bits for this master, two per domain 10..15
  input  wire logic [11:0] blockBits,
  input  wire logic        overrideEn,
  input  wire logic [1:0]  overrideBits,
  // Access request from this master
  input  wire logic        accValid,
  input  wire logic        accWrite,
  input  wire logic [3:0]  accDomain,
  // Verdict
  output logic             accDone,
  output logic             accRefused
);
  import perm_bank_pkg::*;

  logic       inBank;
  logic [3:0] slot;
  logic [3:0] bitSel;
  logic       bankBlock;
  logic       ovrBlock;
  logic       next_refused;

  // Domains below 10 live in another bank and pass here unless the override is enabled
  assign inBank    = (accDomain >= DOM_FIRST_ID) && (accDomain <= DOM_LAST_ID);
  assign slot      = accDomain - DOM_FIRST_ID;
  assign bitSel    = {slot[2:0], accWrite};
  assign bankBlock = inBank && blockBits[bitSel];
  assign ovrBlock  = overrideBits[accWrite ? WRITE_SLOT : READ_SLOT];
  // Override replaces the domain setting entirely
  assign next_refused = overrideEn ? ovrBlock : bankBlock;

  // One-cycle verdict per request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accDone    <= 1'b0;
      accRefused <= 1'b0;
    end else begin
      accDone    <= accValid;
      accRefused <= accValid && next_refused;
    end
  end

endmodule

// ===== logic/iommu_domain_permission_bank.sv
// Domain 10..15 access-permission bank with register slave and access checks
// Operation
// - Domain 12/13 register at 0xC8, resets zero
// - Domain 14/15 register at 0xCC, resets zero
// - Write-block bit 1 refuses master writes
// - Read-block bit 1 refuses master reads
// - Domain 13 in bits 29:16, 31:30 reserved
// - Domain 12 in bits 13:0, 15:14 reserved
// - Domain 15 in bits 29:16, same pairing
// - Domain 14 low half, master 6 at 13:12
// - Domain 10 low, domain 11 high half
// - All non-reserved bits read/write, reset to permitted
// - Seven masters, fourteen bits per domain
// - Override enable replaces all domain settings
// - Refused access raises pending permission error
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module iommu_domain_permission_bank (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // AXI4-Lite write address
  input  wire logic [perm_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [perm_bank_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Master access requests, one lane per master
  input  wire logic [6:0]                    accValid,
  input  wire logic [6:0]                    accWrite,
  input  wire logic [27:0]                   accDomain,
  // Access verdicts
  output logic [6:0]                         accDone,
  output logic [6:0]                         accRefused,
  // Permission vector towards the translation logic
  output logic [31:0]                        permDom10_11,
  output logic [31:0]                        permDom12_13,
  output logic [31:0]                        permDom14_15,
  output logic [31:0]                        permOverride,
  // Permission error pending
  output logic                               permErrIrq
);
  import perm_bank_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0]       dom10_11;
  logic [31:0]       dom12_13;
  logic [31:0]       dom14_15;
  logic [31:0]       overrideReg;
  logic [31:0]       errEnable;
  logic [31:0]       errStatus;

  // ****************************************
  // Write channel state
  // ****************************************
  logic              awHeld;
  logic [ADDR_W-1:0] awAddr;
  logic              wHeld;
  logic [31:0]       wData;
  logic [3:0]        wStrb;
  logic              doWrite;
  logic [31:0]       strbMask;
  logic [ADDR_W-1:0] wrAddr;

  // ****************************************
  // Read channel state
  // ****************************************
  logic              doRead;
  logic [31:0]       next_rdata;
  logic              rdMapped;
  logic [ADDR_W-1:0] rdAddr;
  logic              rdDom10_11;
  logic              rdDom12_13;
  logic              rdDom14_15;
  logic              rdOverride;
  logic              rdErrEnable;
  logic              rdErrClear;
  logic              rdErrStatus;

  // ****************************************
  // Write decode
  // ****************************************
  logic              wrDom10_11;
  logic              wrDom12_13;
  logic              wrDom14_15;
  logic              wrOverride;
  logic              wrErrEnable;
  logic              wrErrClear;
  logic              wrErrStatus;
  logic              wrMapped;
  logic [31:0]       errClear;
  logic [6:0]        errSet;
  logic [6:0]        verdictRefused;
  logic [6:0]        verdictDone;

  // Write fires once address and data are both held and no response waits
  assign doWrite  = awHeld && wHeld && !s_axi_bvalid;
  assign wrAddr   = awAddr;
  assign strbMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};

  // Address decode for writes
  assign wrDom10_11  = doWrite && (wrAddr == OFS_DOM10_11);
  assign wrDom12_13  = doWrite && (wrAddr == OFS_DOM12_13);
  assign wrDom14_15  = doWrite && (wrAddr == OFS_DOM14_15);
  assign wrOverride  = doWrite && (wrAddr == OFS_OVERRIDE);
  assign wrErrEnable = doWrite && (wrAddr == OFS_ERR_ENABLE);
  assign wrErrClear  = doWrite && (wrAddr == OFS_ERR_CLEAR);
  assign wrErrStatus = doWrite && (wrAddr == OFS_ERR_STATUS);
  assign wrMapped    = wrDom10_11 || wrDom12_13 || wrDom14_15 || wrOverride
                    || wrErrEnable || wrErrClear || wrErrStatus;

  // Clear pulses only on written lanes
  assign errClear = wrErrClear ? (wData & strbMask & MASK_ERR) : 32'h0000_0000;

  // ****************************************
  // AXI4-Lite write address and data capture
  // ****************************************
  // Ready flops are the inverse of the hold flags, so each channel takes one item
  assign awHeld = !s_axi_awready;
  assign wHeld  = !s_axi_wready;

  // Address holding register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      awAddr        <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awAddr        <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end else if (doWrite) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Data holding register, taken independently of the address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wData        <= s_axi_wdata;
      wStrb        <= s_axi_wstrb;
    end else if (doWrite) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, SLVERR for holes in the map
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Permission registers
  // ****************************************
  // Reserved bits 31:30 and 15:14 never store, so they read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dom10_11 <= RST_DOMAIN;
    end else if (wrDom10_11) begin
      dom10_11 <= (dom10_11 & ~strbMask) | (wData & strbMask & MASK_DOMAIN);
    end
  end

  // Domains 12 and 13, one short process per register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dom12_13 <= RST_DOMAIN;
    end else if (wrDom12_13) begin
      dom12_13 <= (dom12_13 & ~strbMask) | (wData & strbMask & MASK_DOMAIN);
    end
  end

  // Domains 14 and 15
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dom14_15 <= RST_DOMAIN;
    end else if (wrDom14_15) begin
      dom14_15 <= (dom14_15 & ~strbMask) | (wData & strbMask & MASK_DOMAIN);
    end
  end

  // Override register, enable at bit 31 and per-master pairs below
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overrideReg <= RST_OVERRIDE;
    end else if (wrOverride) begin
      overrideReg <= (overrideReg & ~strbMask) | (wData & strbMask & MASK_OVERRIDE);
    end
  end

  // ****************************************
  // Permission error reporting
  // ****************************************
  // A new refusal wins over a clear in the same cycle
  assign errSet = verdictDone & verdictRefused;

  // Enable mask, one bit per master
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      errEnable <= RST_ERR;
    end else if (wrErrEnable) begin
      errEnable <= (errEnable & ~strbMask) | (wData & strbMask & MASK_ERR);
    end
  end

  // Status is read-only; writes to its offset are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      errStatus <= RST_ERR;
    end else begin
      errStatus <= (errStatus & ~errClear) | {25'h0000000, errSet};
    end
  end

  // Pending error stays up until software clears the cause
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      permErrIrq <= 1'b0;
    end else begin
      permErrIrq <= |(errStatus & errEnable);
    end
  end

  // ****************************************
  // Per-master permission checks
  // ****************************************
  // Each lane gathers its own bit pair from all six domains
  genvar m;
  generate
    for (m = 0; m < MST_COUNT; m = m + 1) begin : gMaster
      logic [11:0] laneBits;
      // Low half holds even domain, high half the odd one
      assign laneBits = {dom14_15[HI_DOMAIN_LSB + 2*m +: 2],
                         dom14_15[2*m +: 2],
                         dom12_13[HI_DOMAIN_LSB + 2*m +: 2],
                         dom12_13[2*m +: 2],
                         dom10_11[HI_DOMAIN_LSB + 2*m +: 2],
                         dom10_11[2*m +: 2]};

      perm_check uCheck (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .blockBits    (laneBits),
        .overrideEn   (overrideReg[OVR_ENABLE_BIT]),
        .overrideBits (overrideReg[2*m +: 2]),
        .accValid     (accValid[m]),
        .accWrite     (accWrite[m]),
        .accDomain    (accDomain[4*m +: 4]),
        .accDone      (verdictDone[m]),
        .accRefused   (verdictRefused[m])
      );
    end
  endgenerate

  // Verdicts leave straight from the lane flip-flops
  assign accDone    = verdictDone;
  assign accRefused = verdictRefused;

  // ****************************************
  // Permission vector outputs
  // ****************************************
  // Driven from the register flip-flops themselves
  assign permDom10_11 = dom10_11;
  assign permDom12_13 = dom12_13;
  assign permDom14_15 = dom14_15;
  assign permOverride = overrideReg;

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // One read at a time; the ready flop is low while data waits
  assign doRead = s_axi_arvalid && s_axi_arready;

  // Read decode on the word address; the clear register is write-only
  assign rdAddr      = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign rdDom10_11  = (rdAddr == OFS_DOM10_11);
  assign rdDom12_13  = (rdAddr == OFS_DOM12_13);
  assign rdDom14_15  = (rdAddr == OFS_DOM14_15);
  assign rdOverride  = (rdAddr == OFS_OVERRIDE);
  assign rdErrEnable = (rdAddr == OFS_ERR_ENABLE);
  assign rdErrClear  = (rdAddr == OFS_ERR_CLEAR);
  assign rdErrStatus = (rdAddr == OFS_ERR_STATUS);
  assign rdMapped    = rdDom10_11 || rdDom12_13 || rdDom14_15 || rdOverride
                    || rdErrEnable || rdErrClear || rdErrStatus;

  // One-hot AND-OR select, so holes and the clear register read zero
  assign next_rdata = ({32{rdDom10_11}} & dom10_11)
                    | ({32{rdDom12_13}} & dom12_13)
                    | ({32{rdDom14_15}} & dom14_15)
                    | ({32{rdOverride}} & overrideReg)
                    | ({32{rdErrEnable}} & errEnable)
                    | ({32{rdErrStatus}} & errStatus);

  // Read response register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid  <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ===== tb/access_master_model.sv
// Behavioural bus masters issuing accesses on the seven lanes
`timescale 1ns/1ps
module access_master_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Request from the bench
  input  wire logic [6:0]  reqLanes,
  input  wire logic        reqWrite,
  input  wire logic [3:0]  reqDomain,
  // Access lanes
  output logic      [6:0]  accValid,
  output logic      [6:0]  accWrite,
  output logic      [27:0] accDomain
);
  import perm_bank_pkg::*;
  // One request per lane per cycle; idle payload is inverted every cycle, so it matches the last request again after two idle cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accValid  <= 7'h00;
      accWrite  <= 7'h00;
      accDomain <= 28'h0000000;
    end else if (reqLanes != 7'h00) begin
      accValid  <= reqLanes;
      accWrite  <= {7{reqWrite}};
      accDomain <= {7{reqDomain}};
    end else begin
      accValid  <= 7'h00;
      accWrite  <= ~accWrite;
      accDomain <= ~accDomain;
    end
  end
endmodule

// ===== tb/perm_bank_assertions.sv
// Concurrent checks on the permission bank ports
`timescale 1ns/1ps
module perm_bank_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Access lanes
  input wire logic [6:0]  accValid,
  input wire logic [6:0]  accWrite,
  input wire logic [27:0] accDomain,
  input wire logic [6:0]  accDone,
  input wire logic [6:0]  accRefused,
  // Register contents
  input wire logic [31:0] permDom10_11,
  input wire logic [31:0] permDom12_13,
  input wire logic [31:0] permDom14_15,
  input wire logic [31:0] permOverride
);
  import perm_bank_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Register contents and bus timing
  // ****************************************
  a_regs_reset_zero:
    assert property ($past(rst) |-> (permDom12_13 | permDom14_15 | permDom10_11) == 32'h0)
    else $error("domain registers not clear after reset");
  a_reserved_read_zero:
    assert property (((permDom10_11 | permDom12_13 | permDom14_15) & 32'hC000_C000) == 32'h0
      && permOverride[30:14] == 17'h0) else $error("reserved bits set");
  a_write_gets_resp:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_gets_data:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_data_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  // ****************************************
  // Access verdicts
  // ****************************************
  a_done_tracks_valid:
    assert property (accValid != 7'h00 |=> accDone == $past(accValid))
    else $error("access done mismatch");
  a_refused_with_done:
    assert property (accRefused != 7'h00 |-> (accRefused & ~accDone) == 7'h00)
    else $error("refusal without done");
  a_lane0_read_dom12:
    assert property (accValid[0] && !accWrite[0] && !permOverride[31] && accDomain[3:0] == 4'hC
      |=> accRefused[0] == $past(permDom12_13[0])) else $error("lane 0 read verdict");
  a_lane6_write_dom15:
    assert property (accValid[6] && accWrite[6] && !permOverride[31] && accDomain[27:24] == 4'hF
      |=> accRefused[6] == $past(permDom14_15[29])) else $error("lane 6 write verdict");
  a_override_lane0:
    assert property (accValid[0] && accWrite[0] && permOverride[31]
      |=> accRefused[0] == $past(permOverride[1])) else $error("override verdict");
endmodule
bind iommu_domain_permission_bank perm_bank_assertions i_perm_bank_assertions (
  .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .accValid(accValid),
  .accWrite(accWrite), .accDomain(accDomain), .accDone(accDone), .accRefused(accRefused),
  .permDom10_11(permDom10_11), .permDom12_13(permDom12_13), .permDom14_15(permDom14_15),
  .permOverride(permOverride));

// ===== tb/tb.sv
// Self-checking bench for the domain permission bank
`timescale 1ns/1ps
module tb;
  import perm_bank_pkg::*;
  logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_arvalid, s_axi_rvalid;
  logic        s_axi_rready, reqWrite, permErrIrq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, permDom10_11, permDom12_13, permDom14_15, permOverride;
  logic [3:0]  s_axi_wstrb, reqDomain;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  accValid, accWrite, accDone, accRefused, reqLanes;
  logic [27:0] accDomain;
  logic [11:0] regs [3] = '{OFS_DOM10_11, OFS_DOM12_13, OFS_DOM14_15};
  int          compares, miscompares, cycles;
  iommu_domain_permission_bank i_iommu_domain_permission_bank (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .accValid(accValid),
    .accWrite(accWrite), .accDomain(accDomain), .accDone(accDone), .accRefused(accRefused),
    .permDom10_11(permDom10_11), .permDom12_13(permDom12_13), .permDom14_15(permDom14_15),
    .permOverride(permOverride), .permErrIrq(permErrIrq));
  access_master_model i_access_master_model (.sys_clk(sys_clk), .rst(rst), .reqLanes(reqLanes),
    .reqWrite(reqWrite), .reqDomain(reqDomain), .accValid(accValid), .accWrite(accWrite),
    .accDomain(accDomain));
  // ****************************************
  // Clock, watchdog and checking tasks
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Ceiling well above the under two hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // Ready raised only after data shows, so the slave must hold it
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (er == RESP_OKAY) chk("rdata", e, s_axi_rdata);
  endtask
  // All seven lanes request the same domain at once
  task automatic access(input logic w, input logic [3:0] dom, input logic [6:0] expRef);
    int n;
    @(posedge sys_clk);
    reqLanes <= 7'h7F;
    reqWrite <= w;
    reqDomain <= dom;
    @(posedge sys_clk);
    reqLanes <= 7'h00;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (accDone == 7'h00 && n < 4);
    chk("accDone", 32'h7F, {25'h0, accDone});
    chk("accRefused", {25'h0, expRef}, {25'h0, accRefused});
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h3F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {reqLanes, reqWrite, reqDomain} = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[i]) reg_rd(regs[i], 32'h0, RESP_OKAY);
    reg_rd(OFS_OVERRIDE, 32'h0, RESP_OKAY);
    $display("test reset values done");
    foreach (regs[i]) begin
      reg_wr(regs[i], 32'hFFFF_FFFF, RESP_OKAY);
      reg_rd(regs[i], 32'h3FFF_3FFF, RESP_OKAY);
      reg_wr(regs[i], 32'h0, RESP_OKAY);
    end
    reg_wr(12'h0F0, 32'hFFFF_FFFF, RESP_SLVERR);
    reg_rd(12'h0F0, 32'h0, RESP_SLVERR);
    $display("test register layout done");
    access(1'b0, 4'hC, 7'h00);
    reg_wr(OFS_DOM12_13, 32'h2000_0001, RESP_OKAY);
    access(1'b0, 4'hC, 7'h01);
    access(1'b1, 4'hD, 7'h40);
    access(1'b0, 4'hD, 7'h00);
    reg_wr(OFS_DOM14_15, 32'h0001_3000, RESP_OKAY);
    access(1'b0, 4'hE, 7'h40);
    access(1'b1, 4'hE, 7'h40);
    access(1'b0, 4'hF, 7'h01);
    access(1'b1, 4'hF, 7'h00);
    reg_wr(OFS_DOM10_11, 32'h0001_2000, RESP_OKAY);
    access(1'b1, 4'hA, 7'h40);
    access(1'b0, 4'hB, 7'h01);
    access(1'b1, 4'h2, 7'h00);
    $display("test access verdicts done");
    reg_wr(OFS_OVERRIDE, 32'hFFFF_FFFF, RESP_OKAY);
    reg_rd(OFS_OVERRIDE, 32'h8000_3FFF, RESP_OKAY);
    reg_wr(OFS_OVERRIDE, 32'h8000_0002, RESP_OKAY);
    access(1'b1, 4'hC, 7'h01);
    access(1'b0, 4'hC, 7'h00);
    $display("test override done");
    reg_rd(OFS_ERR_STATUS, 32'h41, RESP_OKAY);
    chk("permErrIrq", 32'h0, {31'h0, permErrIrq});
    reg_wr(OFS_ERR_ENABLE, 32'h7F, RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("permErrIrq", 32'h1, {31'h0, permErrIrq});
    reg_wr(OFS_ERR_CLEAR, 32'h41, RESP_OKAY);
    reg_rd(OFS_ERR_STATUS, 32'h0, RESP_OKAY);
    chk("permErrIrq", 32'h0, {31'h0, permErrIrq});
    $display("test permission error done");
    give_verdict();
  end
endmodule
